// File: design/mbcr_core.sv
// request interpreter for coil force, register read and register preset
`timescale 1ns/1ps
`include "mbcr_cfg.svh"

// Summary of operation
// - function 05 drives the addressed coil on or off from force data.
// - force data FF00 means on, 0000 means off; other values rejected.
// - broadcast coil forces are applied exactly like addressed ones.
// - coil addresses start at zero; address n is coil n, bit n of coilState.
// - single coil is updated before its echo response is sent.
// - function 0F sets a contiguous coil run from packed data bits.
// - multiple coil reply holds slave, function, start and quantity only.
// - function 03 returns contents of a contiguous holding register range.
// - broadcast reads are never accepted.
// - read reply has byte count then each register high byte first.
// - preset register addresses start at zero.
// - function 06 writes sixteen-bit data, high byte first, to one register.
// - broadcast presets are applied exactly like addressed ones.
// - single preset echo is sent after register contents are passed on.
// - function 10 writes a contiguous run of holding registers.
// - multiple preset reply holds slave, function, start and count.
// - lowest coil sits in bit zero of first data byte.
// - errors on addressed requests return function with top bit set plus an error code; broadcast errors get no reply.
module mbcr_core #(
    parameter int NUM_COILS = 64,
    parameter int REG_DEPTH = 64,
    parameter int MAX_BYTES = 16,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] ownAddr,
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    input wire logic rxEnd,
    output logic rxReady,
    output logic txValid,
    output logic [7:0] txData,
    output logic txLast,
    input wire logic txReady,
    output logic [NUM_COILS-1:0] coilState,
    output logic regWrValid,
    output logic [15:0] regWrAddr,
    output logic [15:0] regWrData,
    output mbcr_pkg::mbcr_state_t state
);
    import mbcr_pkg::*;

    localparam int CAW = $clog2(NUM_COILS);
    localparam int RAW = $clog2(REG_DEPTH);
    localparam int BAW = $clog2(MAX_BYTES);

    // ------------------------------------------------------------
    // crc
    // ------------------------------------------------------------
    function automatic logic [15:0] crcUpd(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `MBCR_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    mbcr_state_t state_q, state_d;
    logic [7:0] byteCnt_q, byteCnt_d;
    logic [15:0] crc_q, crc_d;
    logic [7:0] slv_q, slv_d;
    logic [7:0] func_q, func_d;
    logic [15:0] fieldA_q, fieldA_d;
    logic [15:0] fieldB_q, fieldB_d;
    logic [7:0] bcnt_q, bcnt_d;
    logic [7:0] dataBuf_q [MAX_BYTES];
    logic [7:0] dataBuf_d [MAX_BYTES];
    logic [7:0] exc_q, exc_d;
    logic [7:0] idx_q, idx_d;
    logic [15:0] txCrc_q, txCrc_d;
    logic wait_q, wait_d;
    logic [NUM_COILS-1:0] coils_q, coils_d;
    logic regWrValid_q, regWrValid_d;
    logic [15:0] regWrAddr_q, regWrAddr_d;
    logic [15:0] regWrData_q, regWrData_d;

    logic [16:0] runEnd;
    logic [16:0] coilBytes;
    logic lenFixed, lenVar, isBcast, accept;
    logic [7:0] excCode;
    logic [NUM_COILS-1:0] inRun, forceBit;
    logic memWrEn;
    logic [RAW-1:0] memWrAddr, memRdAddr;
    logic [15:0] memWrData, memRdData, rdWord, preWord;
    logic [7:0] rdOff, payloadLen, txByte;
    logic fifoInValid, fifoInReady, txIsLast;
    logic [8:0] fifoOut;

    assign runEnd = {1'b0, fieldA_q} + {1'b0, fieldB_q};
    assign coilBytes = ({1'b0, fieldB_q} + 17'h00007) >> 3;
    assign lenFixed = (byteCnt_q == `MBCR_FIXED_LEN);
    assign lenVar = (byteCnt_q == 8'(bcnt_q + `MBCR_IDX_DATA + `MBCR_CRC_LEN));
    assign isBcast = (slv_q == `MBCR_BCAST_ADDR);
    assign accept = (crc_q == `MBCR_CRC_RESIDUE) && (byteCnt_q >= `MBCR_MIN_LEN) &&
                    ((slv_q == ownAddr) || isBcast) &&
                    !(isBcast && (func_q == `MBCR_FN_READ_REGS));

    // ------------------------------------------------------------
    // request validation
    // ------------------------------------------------------------
    always_comb begin
        excCode = `MBCR_EXC_NONE;
        case (func_q)
            `MBCR_FN_FORCE_ONE: begin
                if (!lenFixed) begin
                    excCode = `MBCR_EXC_BAD_LEN;
                end else if ((fieldB_q != `MBCR_FORCE_ON) && (fieldB_q != `MBCR_FORCE_OFF)) begin
                    excCode = `MBCR_EXC_BAD_VALUE;
                end else if ({1'b0, fieldA_q} >= 17'(NUM_COILS)) begin
                    excCode = `MBCR_EXC_BAD_ADDR;
                end
            end
            `MBCR_FN_FORCE_MANY: begin
                if (!lenVar) begin
                    excCode = `MBCR_EXC_BAD_LEN;
                end else if ((fieldB_q == '0) || ({9'h000, bcnt_q} != coilBytes) ||
                             ({9'h000, bcnt_q} > 17'(MAX_BYTES))) begin
                    excCode = `MBCR_EXC_BAD_VALUE;
                end else if (runEnd > 17'(NUM_COILS)) begin
                    excCode = `MBCR_EXC_BAD_ADDR;
                end
            end
            `MBCR_FN_READ_REGS: begin
                if (!lenFixed) begin
                    excCode = `MBCR_EXC_BAD_LEN;
                end else if ((fieldB_q == '0) || (fieldB_q > `MBCR_MAX_READ)) begin
                    excCode = `MBCR_EXC_BAD_VALUE;
                end else if (runEnd > 17'(REG_DEPTH)) begin
                    excCode = `MBCR_EXC_BAD_ADDR;
                end
            end
            `MBCR_FN_PRESET_ONE: begin
                if (!lenFixed) begin
                    excCode = `MBCR_EXC_BAD_LEN;
                end else if ({1'b0, fieldA_q} >= 17'(REG_DEPTH)) begin
                    excCode = `MBCR_EXC_BAD_ADDR;
                end
            end
            `MBCR_FN_PRESET_MANY: begin
                if (!lenVar) begin
                    excCode = `MBCR_EXC_BAD_LEN;
                end else if ((fieldB_q == '0) || ({9'h000, bcnt_q} != {fieldB_q, 1'b0}) ||
                             ({9'h000, bcnt_q} > 17'(MAX_BYTES))) begin
                    excCode = `MBCR_EXC_BAD_VALUE;
                end else if (runEnd > 17'(REG_DEPTH)) begin
                    excCode = `MBCR_EXC_BAD_ADDR;
                end
            end
            default: excCode = `MBCR_EXC_BAD_FUNC;
        endcase
    end

    // ------------------------------------------------------------
    // coil run decode
    // ------------------------------------------------------------
    for (genvar j = 0; j < NUM_COILS; j++) begin : gCoil
        logic [15:0] off;
        assign off = 16'(j) - fieldA_q;
        assign inRun[j] = (16'(j) >= fieldA_q) && (off < fieldB_q);
        assign forceBit[j] = dataBuf_q[off[BAW+2:3]][off[2:0]];
    end

    // ------------------------------------------------------------
    // response byte selection
    // ------------------------------------------------------------
    assign rdOff = idx_q - `MBCR_READ_HDR;
    assign memRdAddr = RAW'(fieldA_q + {9'h000, rdOff[7:1]});
    assign rdWord = memRdData;
    assign preWord = {dataBuf_q[BAW'({idx_q, 1'b0})], dataBuf_q[BAW'({idx_q, 1'b1})]};

    always_comb begin
        txByte = slv_q;
        if (exc_q != `MBCR_EXC_NONE) begin
            payloadLen = `MBCR_EXC_LEN;
        end else if (func_q == `MBCR_FN_READ_REGS) begin
            payloadLen = 8'(`MBCR_READ_HDR + {fieldB_q[6:0], 1'b0});
        end else begin
            payloadLen = `MBCR_ECHO_LEN;
        end
        if (idx_q == payloadLen) begin
            txByte = txCrc_q[7:0];
        end else if (idx_q > payloadLen) begin
            txByte = txCrc_q[15:8];
        end else if (idx_q == `MBCR_IDX_FUNC) begin
            txByte = (exc_q != `MBCR_EXC_NONE) ? (func_q | `MBCR_EXC_FLAG) : func_q;
        end else if ((idx_q == `MBCR_IDX_A_HI) && (exc_q != `MBCR_EXC_NONE)) begin
            txByte = exc_q;
        end else if (func_q == `MBCR_FN_READ_REGS) begin
            if (idx_q == `MBCR_IDX_A_HI) begin
                txByte = {fieldB_q[6:0], 1'b0};
            end else if (idx_q != `MBCR_IDX_SLAVE) begin
                txByte = rdOff[0] ? rdWord[7:0] : rdWord[15:8];
            end
        end else if (idx_q == `MBCR_IDX_A_HI) begin
            txByte = fieldA_q[15:8];
        end else if (idx_q == `MBCR_IDX_A_LO) begin
            txByte = fieldA_q[7:0];
        end else if (idx_q == `MBCR_IDX_B_HI) begin
            txByte = fieldB_q[15:8];
        end else if (idx_q == `MBCR_IDX_B_LO) begin
            txByte = fieldB_q[7:0];
        end
    end

    assign txIsLast = (idx_q == 8'(payloadLen + 8'h01));
    assign fifoInValid = (state_q == MBCR_RESP) && !wait_q;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        byteCnt_d = byteCnt_q;
        crc_d = crc_q;
        slv_d = slv_q;
        func_d = func_q;
        fieldA_d = fieldA_q;
        fieldB_d = fieldB_q;
        bcnt_d = bcnt_q;
        dataBuf_d = dataBuf_q;
        exc_d = exc_q;
        idx_d = idx_q;
        txCrc_d = txCrc_q;
        wait_d = 1'b0;
        coils_d = coils_q;
        regWrValid_d = 1'b0;
        regWrAddr_d = regWrAddr_q;
        regWrData_d = regWrData_q;
        memWrEn = 1'b0;
        memWrAddr = RAW'(fieldA_q);
        memWrData = fieldB_q;
        case (state_q)
            MBCR_RX: begin
                if (rxEnd && (byteCnt_q != '0)) begin
                    state_d = MBCR_CHECK;
                end else if (rxValid) begin
                    crc_d = crcUpd(crc_q, rxData);
                    byteCnt_d = (byteCnt_q == `MBCR_CNT_MAX) ? byteCnt_q : byteCnt_q + 8'h01;
                    if (byteCnt_q == `MBCR_IDX_SLAVE) begin
                        slv_d = rxData;
                    end else if (byteCnt_q == `MBCR_IDX_FUNC) begin
                        func_d = rxData;
                    end else if (byteCnt_q == `MBCR_IDX_A_HI) begin
                        fieldA_d[15:8] = rxData;
                    end else if (byteCnt_q == `MBCR_IDX_A_LO) begin
                        fieldA_d[7:0] = rxData;
                    end else if (byteCnt_q == `MBCR_IDX_B_HI) begin
                        fieldB_d[15:8] = rxData;
                    end else if (byteCnt_q == `MBCR_IDX_B_LO) begin
                        fieldB_d[7:0] = rxData;
                    end else if (byteCnt_q == `MBCR_IDX_BCNT) begin
                        bcnt_d = rxData;
                    end else if ((byteCnt_q - `MBCR_IDX_DATA) < 8'(MAX_BYTES)) begin
                        dataBuf_d[BAW'(byteCnt_q - `MBCR_IDX_DATA)] = rxData;
                    end
                end
            end
            MBCR_CHECK: begin
                byteCnt_d = '0;
                crc_d = `MBCR_CRC_INIT;
                idx_d = '0;
                txCrc_d = `MBCR_CRC_INIT;
                exc_d = excCode;
                if (!accept) begin
                    state_d = MBCR_RX;
                end else if (excCode != `MBCR_EXC_NONE) begin
                    state_d = isBcast ? MBCR_RX : MBCR_RESP;
                end else begin
                    state_d = MBCR_COMMIT;
                end
            end
            MBCR_COMMIT: begin
                // broadcast and addressed writes take the same path
                state_d = isBcast ? MBCR_RX : MBCR_RESP;
                if (func_q == `MBCR_FN_FORCE_ONE) begin
                    coils_d[CAW'(fieldA_q)] = (fieldB_q == `MBCR_FORCE_ON);
                end else if (func_q == `MBCR_FN_FORCE_MANY) begin
                    coils_d = (coils_q & ~inRun) | (forceBit & inRun);
                end else if (func_q == `MBCR_FN_PRESET_ONE) begin
                    memWrEn = 1'b1;
                    regWrValid_d = 1'b1;
                    regWrAddr_d = fieldA_q;
                    regWrData_d = fieldB_q;
                end else if (func_q == `MBCR_FN_PRESET_MANY) begin
                    // one register a cycle, high byte first
                    memWrEn = 1'b1;
                    memWrAddr = RAW'(fieldA_q + {8'h00, idx_q});
                    memWrData = preWord;
                    regWrValid_d = 1'b1;
                    regWrAddr_d = fieldA_q + {8'h00, idx_q};
                    regWrData_d = preWord;
                    idx_d = idx_q + 8'h01;
                    if ({8'h00, idx_d} != fieldB_q) begin
                        state_d = MBCR_COMMIT;
                    end else begin
                        idx_d = '0;
                    end
                end
            end
            MBCR_RESP: begin
                wait_d = wait_q;
                if (wait_q) begin
                    wait_d = 1'b0;
                end else if (fifoInReady) begin
                    if (idx_q < payloadLen) begin
                        txCrc_d = crcUpd(txCrc_q, txByte);
                    end
                    idx_d = idx_q + 8'h01;
                    // read data lag one cycle behind the address
                    wait_d = (func_q == `MBCR_FN_READ_REGS) && (exc_q == `MBCR_EXC_NONE);
                    if (txIsLast) begin
                        state_d = MBCR_RX;
                        idx_d = '0;
                        wait_d = 1'b0;
                    end
                end
            end
            default: state_d = MBCR_RX;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= MBCR_RX;
            byteCnt_q <= '0;
            crc_q <= `MBCR_CRC_INIT;
            slv_q <= '0;
            func_q <= '0;
            fieldA_q <= '0;
            fieldB_q <= '0;
            bcnt_q <= '0;
            dataBuf_q <= '{default: 8'h00};
            exc_q <= `MBCR_EXC_NONE;
            idx_q <= '0;
            txCrc_q <= `MBCR_CRC_INIT;
            wait_q <= 1'b0;
            coils_q <= '0;
            regWrValid_q <= 1'b0;
            regWrAddr_q <= '0;
            regWrData_q <= '0;
        end else begin
            state_q <= state_d;
            byteCnt_q <= byteCnt_d;
            crc_q <= crc_d;
            slv_q <= slv_d;
            func_q <= func_d;
            fieldA_q <= fieldA_d;
            fieldB_q <= fieldB_d;
            bcnt_q <= bcnt_d;
            dataBuf_q <= dataBuf_d;
            exc_q <= exc_d;
            idx_q <= idx_d;
            txCrc_q <= txCrc_d;
            wait_q <= wait_d;
            coils_q <= coils_d;
            regWrValid_q <= regWrValid_d;
            regWrAddr_q <= regWrAddr_d;
            regWrData_q <= regWrData_d;
        end
    end

    // ------------------------------------------------------------
    // storage and output buffering
    // ------------------------------------------------------------
    mbcr_mem #(.WIDTH(16), .DEPTH(REG_DEPTH)) uMem (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .wrEn(memWrEn),
        .wrAddr(memWrAddr),
        .wrData(memWrData),
        .rdAddr(memRdAddr),
        .rdData(memRdData)
    );

    mbcr_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) uFifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .inValid(fifoInValid),
        .inData({txIsLast, txByte}),
        .inReady(fifoInReady),
        .outValid(txValid),
        .outData(fifoOut),
        .outReady(txReady)
    );

    // bytes arriving outside reception are not held
    assign rxReady = (state_q == MBCR_RX);
    assign txData = fifoOut[7:0];
    assign txLast = fifoOut[8];
    assign coilState = coils_q;
    assign regWrValid = regWrValid_q;
    assign regWrAddr = regWrAddr_q;
    assign regWrData = regWrData_q;
    assign state = state_q;
endmodule

// File: pkg/mbcr_cfg.svh
// constants of the coil and holding-register request handler
`ifndef MBCR_CFG_SVH
`define MBCR_CFG_SVH

// ------------------------------------------------------------
// function codes
// ------------------------------------------------------------
`define MBCR_FN_FORCE_ONE 8'h05
`define MBCR_FN_FORCE_MANY 8'h0F
`define MBCR_FN_READ_REGS 8'h03
`define MBCR_FN_PRESET_ONE 8'h06
`define MBCR_FN_PRESET_MANY 8'h10

// ------------------------------------------------------------
// exception handling
// ------------------------------------------------------------
`define MBCR_EXC_FLAG 8'h80
`define MBCR_EXC_NONE 8'h00
`define MBCR_EXC_BAD_ADDR 8'h40
`define MBCR_EXC_BAD_LEN 8'h41
`define MBCR_EXC_BAD_VALUE 8'h42
`define MBCR_EXC_BAD_FUNC 8'h43

// ------------------------------------------------------------
// field values and frame layout
// ------------------------------------------------------------
`define MBCR_FORCE_ON 16'hFF00
`define MBCR_FORCE_OFF 16'h0000
`define MBCR_BCAST_ADDR 8'h00
`define MBCR_CRC_INIT 16'hFFFF
`define MBCR_CRC_POLY 16'hA001
`define MBCR_CRC_RESIDUE 16'h0000
`define MBCR_CNT_MAX 8'hFF
`define MBCR_IDX_SLAVE 8'h00
`define MBCR_IDX_FUNC 8'h01
`define MBCR_IDX_A_HI 8'h02
`define MBCR_IDX_A_LO 8'h03
`define MBCR_IDX_B_HI 8'h04
`define MBCR_IDX_B_LO 8'h05
`define MBCR_IDX_BCNT 8'h06
`define MBCR_IDX_DATA 8'h07
`define MBCR_MIN_LEN 8'h04
`define MBCR_FIXED_LEN 8'h08
`define MBCR_CRC_LEN 8'h02
`define MBCR_ECHO_LEN 8'h06
`define MBCR_EXC_LEN 8'h03
`define MBCR_READ_HDR 8'h03
`define MBCR_MAX_READ 16'h007D

`endif

// File: pkg/mbcr_pkg.sv
// types of the coil and holding-register request handler
package mbcr_pkg;
    typedef enum logic [1:0] {
        MBCR_RX = 2'b00,
        MBCR_CHECK = 2'b01,
        MBCR_COMMIT = 2'b10,
        MBCR_RESP = 2'b11
    } mbcr_state_t;
endpackage

// File: design/mbcr_fifo.sv
// response byte fifo with valid/ready on both sides
`timescale 1ns/1ps
module mbcr_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [AW:0] count_q, count_d;
    logic push, pop;

    assign inReady = (count_q != (AW+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData = mem_q[rdPtr_q];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        wrPtr_d = wrPtr_q;
        rdPtr_d = rdPtr_q;
        count_d = count_q;
        if (push) begin
            wrPtr_d = (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
        end
        if (pop) begin
            rdPtr_d = (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
        end
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
        end
    end

    // storage is not reset; empty flag guards stale words
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wrPtr_q] <= inData;
        end
    end
endmodule

// File: design/mbcr_mem.sv
// holding register storage with registered read data
`timescale 1ns/1ps
module mbcr_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 64
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wrEn,
    input wire logic [$clog2(DEPTH)-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic [$clog2(DEPTH)-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    always_ff @(posedge core_clk) begin
        if (wrEn) begin
            mem_q[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData <= '0;
        end else begin
            rdData <= mem_q[rdAddr];
        end
    end
endmodule

// File: tb/mbcr_master.sv
// bus master model: sends request frames, collects reply bytes
`timescale 1ns/1ps
module mbcr_master (
    input wire logic core_clk,
    input wire logic rxReady,
    output logic rxValid = 1'b0,
    output logic [7:0] rxData = 8'h00,
    output logic rxEnd = 1'b0,
    input wire logic txValid,
    input wire logic [7:0] txData,
    input wire logic txLast,
    output logic txReady = 1'b1
);
    logic [8:0] got[$];
    logic slow = 1'b0;
    function automatic logic [15:0] crc(logic [7:0] b[$]);
        logic [15:0] c = 16'hFFFF;
        foreach (b[i]) begin
            c ^= {8'h00, b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction
    // slow mode drops ready every other cycle to stall the reply fifo
    always @(posedge core_clk) begin
        if (txValid && txReady) got.push_back({txLast, txData});
        txReady <= slow ? ~txReady : 1'b1;
    end
    // fields high byte first, check low byte first
    task automatic send(logic [95:0] v, int n, bit bad);
        logic [7:0] b[$];
        logic [15:0] c;
        for (int i = n - 1; i >= 0; i--) b.push_back(v[8*i +: 8]);
        c = crc(b) ^ {15'h0000, bad};
        b = {b, c[7:0], c[15:8]};
        while (rxReady !== 1'b1) @(posedge core_clk);
        foreach (b[i]) begin
            @(posedge core_clk);
            rxValid <= 1'b1;
            rxData <= b[i];
        end
        @(posedge core_clk);
        rxValid <= 1'b0;
        // idle line never keeps the last byte
        rxData <= ~rxData;
        rxEnd <= 1'b1;
        @(posedge core_clk);
        rxEnd <= 1'b0;
    endtask
endmodule

// File: tb/mbcr_core_sva.sv
// port assertions of the request handler
`timescale 1ns/1ps
module mbcr_core_sva #(parameter int NUM_COILS = 64) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic rxReady,
    input wire logic txValid,
    input wire logic [7:0] txData,
    input wire logic txReady,
    input wire logic [NUM_COILS-1:0] coilState,
    input wire logic regWrValid,
    input wire mbcr_pkg::mbcr_state_t state
);
    import mbcr_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    rx_ready_a: assert property (rxReady == (state == MBCR_RX)) else $error("rx ready");
    check_one_a: assert property (state == MBCR_CHECK |=> state inside {MBCR_COMMIT, MBCR_RX, MBCR_RESP}) else $error("check");
    coil_commit_a: assert property ($changed(coilState) |-> $past(state) == MBCR_COMMIT) else $error("coil");
    coil_first_a: assert property ($changed(coilState) |-> !txValid) else $error("coil late");
    wr_commit_a: assert property (regWrValid |-> $past(state) == MBCR_COMMIT) else $error("write");
    wr_first_a: assert property (regWrValid |-> !txValid) else $error("write late");
    tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txData)) else $error("tx moved");
    resp_end_a: assert property ($rose(state == MBCR_RESP) |-> ##[1:1000] state == MBCR_RX) else $error("stuck");
    cover property (regWrValid);
    cover property ($changed(coilState));
    cover property (txValid && !txReady);
endmodule
bind mbcr_core mbcr_core_sva #(.NUM_COILS(NUM_COILS)) u_sva (.core_clk(core_clk), .rst_n(rst_n),
    .rxReady(rxReady), .txValid(txValid), .txData(txData), .txReady(txReady), .coilState(coilState),
    .regWrValid(regWrValid), .state(state));

// File: tb/mbcr_core_test.sv
// bench of the request handler against the master model
`timescale 1ns/1ps
module mbcr_core_test;
    import mbcr_pkg::*;
    typedef struct {logic [95:0] rq; int rqN; logic [95:0] rs; int rsN; logic [63:0] coil;} mbcr_row_t;
    mbcr_row_t rows[6];
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic rxValid, rxEnd, rxReady, txValid, txLast, txReady;
    logic [7:0] rxData, txData;
    logic [63:0] coilState;
    logic regWrValid;
    logic [15:0] regWrAddr, regWrData;
    logic [31:0] lastWr = 32'h0;
    mbcr_state_t state;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    mbcr_core u_dut (.core_clk(core_clk), .rst_n(rst_n), .ownAddr(8'h01), .rxValid(rxValid), .rxData(rxData),
        .rxEnd(rxEnd), .rxReady(rxReady), .txValid(txValid), .txData(txData), .txLast(txLast), .txReady(txReady),
        .coilState(coilState), .regWrValid(regWrValid), .regWrAddr(regWrAddr), .regWrData(regWrData),
        .state(state));
    mbcr_master u_mst (.core_clk(core_clk), .rxReady(rxReady), .rxValid(rxValid), .rxData(rxData), .rxEnd(rxEnd),
        .txValid(txValid), .txData(txData), .txLast(txLast), .txReady(txReady));
    initial forever #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (regWrValid === 1'b1) lastWr <= {regWrAddr, regWrData};
    end
    always @(posedge core_clk) begin
        if (++cycles == 20000) begin
            failures++;
            stop_test();
        end
    end
    task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic run(logic [95:0] rq, int n, bit bad, logic [95:0] rs, int rn);
        logic [7:0] b[$];
        logic [15:0] c;
        int t = 0;
        u_mst.got.delete();
        u_mst.send(rq, n, bad);
        for (int i = rn - 1; i >= 0; i--) b.push_back(rs[8*i +: 8]);
        c = u_mst.crc(b);
        if (rn > 0) b = {b, c[7:0], c[15:8]};
        repeat (600) begin
            @(posedge core_clk);
            if (++t > 30 && state == MBCR_RX && txValid === 1'b0) break;
        end
        chk("reply length", b.size(), u_mst.got.size());
        foreach (b[i]) chk("reply byte", {i == b.size() - 1, b[i]}, u_mst.got[i]);
        $display("request %h done", rq);
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        rows = '{'{96'h010600010003, 6, 96'h010600010003, 6, 64'h0},
            '{96'h01100002000204000002E2, 11, 96'h011000020002, 6, 64'h0},
            '{96'h010300010003, 6, 96'h0103060003000002E2, 9, 64'h0},
            '{96'h01050003FF00, 6, 96'h01050003FF00, 6, 64'h8},
            '{96'h010F0008000A02FF03, 9, 96'h010F0008000A, 6, 64'h3FF08},
            '{96'h010500030000, 6, 96'h010500030000, 6, 64'h3FF00}};
        repeat (12) @(posedge core_clk);
        chk("reset coils", 64'h0, coilState);
        chk("reset state", MBCR_RX, state);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            run(rows[i].rq, rows[i].rqN, 1'b0, rows[i].rs, rows[i].rsN);
            chk("coils", rows[i].coil, coilState);
        end
        chk("last write", 64'h000302E2, lastWr);
        u_mst.slow <= 1'b1;
        run(96'h010500031234, 6, 1'b0, 96'h018542, 3);
        run(96'h00050007FF00, 6, 1'b0, 96'h0, 0);
        chk("broadcast coil", 64'h3FF80, coilState);
        run(96'h000600050077, 6, 1'b0, 96'h0, 0);
        run(96'h010600050011, 6, 1'b1, 96'h0, 0);
        run(96'h020600050022, 6, 1'b0, 96'h0, 0);
        run(96'h000300050001, 6, 1'b0, 96'h0, 0);
        run(96'h010300050001, 6, 1'b0, 96'h0103020077, 5);
        chk("last write", 64'h00050077, lastWr);
        run(96'h010100000001, 6, 1'b0, 96'h018143, 3);
        run(96'h010600400001, 6, 1'b0, 96'h018640, 3);
        run(96'h01050003FF, 5, 1'b0, 96'h018541, 3);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("mid reset coils", 64'h0, coilState);
        rst_n <= 1'b1;
        run(96'h01050000FF00, 6, 1'b0, 96'h01050000FF00, 6);
        chk("coil zero", 64'h1, coilState);
        stop_test();
    end
endmodule
